// file: verilog/scrwc_consts.svh
// Offsets, bit positions, reset values and timing counts of the clock/reset/wake controller
`ifndef SCRWC_CONSTS_SVH
`define SCRWC_CONSTS_SVH
`define SCRWC_CLK_PERIOD_NS 100
`define SCRWC_RST_HOLD_NS   1000
`define SCRWC_RST_HOLD_CYC  ((`SCRWC_RST_HOLD_NS + `SCRWC_CLK_PERIOD_NS - 1) / `SCRWC_CLK_PERIOD_NS)
`define SCRWC_TICK_NS       1000
`define SCRWC_TICK_CYC      (`SCRWC_TICK_NS / `SCRWC_CLK_PERIOD_NS)
`define SCRWC_NCH           5
`define SCRWC_CH_DIG        0
`define SCRWC_CH_SOFT       1
`define SCRWC_CH_P1         2
`define SCRWC_CH_P2         3
`define SCRWC_CH_VIRT       4
`define SCRWC_OFF_RST_CTL   8'h00
`define SCRWC_OFF_HARDWARE_CONFIG_REG    8'h04
`define SCRWC_OFF_PMT       8'h08
`define SCRWC_OFF_WAKE_STS  8'h0C
`define SCRWC_OFF_P1_BASIC  8'h10
`define SCRWC_OFF_P2_BASIC  8'h14
`define SCRWC_OFF_V_BASIC   8'h18
`define SCRWC_OFF_TMR_CTL   8'h1C
`define SCRWC_OFF_TMR_CNT   8'h20
`define SCRWC_OFF_FREE_CNT  8'h24
`define SCRWC_OFF_INT_STS   8'h28
`define SCRWC_OFF_INT_MASK  8'h2C
`define SCRWC_OFF_SCRATCH   8'h30
`define SCRWC_BIT_DIG_RST   0
`define SCRWC_BIT_P1_RST    1
`define SCRWC_BIT_P2_RST    2
`define SCRWC_BIT_SOFT_RST  0
`define SCRWC_BIT_PMT_VRST  10
`define SCRWC_BIT_PMT_WOUT  3
`define SCRWC_BIT_BASIC_RST 15
`define SCRWC_BIT_TMR_EN    16
`define SCRWC_TMR_RELOAD_RST 16'hFFFF
`define SCRWC_INT_TIMER     0
`define SCRWC_INT_WAKE      1
`define SCRWC_INT_RSTDONE   2
`endif

// file: verilog/scrwc_pkg.sv
// Types of the clock/reset/wake controller
package scrwc_pkg;
    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_HOLD = 1'b1
    } scrwc_seq_state_type;
endpackage : scrwc_pkg

// file: verilog/scrwc_rst_seq.sv
// Per-channel reset pulse sequencer
`timescale 1ns/1ps
`include "scrwc_consts.svh"
module scrwc_rst_seq
    import scrwc_pkg::*;
(
    // Clock and reset
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // Requests and status
    input  wire logic [`SCRWC_NCH-1:0]    start,
    output logic      [`SCRWC_NCH-1:0]    active,
    output logic      [`SCRWC_NCH-1:0]    done
);
    localparam logic [7:0] HOLD_LAST = 8'(`SCRWC_RST_HOLD_CYC - 1);
    genvar i;
    for (i = 0; i < `SCRWC_NCH; i = i + 1) begin : g_ch
        scrwc_seq_state_type st_reg, st_next;
        logic [7:0]          cnt_reg, cnt_next;
        always_comb begin
            st_next  = st_reg;
            cnt_next = cnt_reg;
            case (st_reg)
                SEQ_IDLE: begin
                    if (start[i]) begin
                        st_next  = SEQ_HOLD;
                        cnt_next = HOLD_LAST;
                    end
                end
                SEQ_HOLD: begin
                    if (cnt_reg == 8'h00) begin
                        st_next = SEQ_IDLE;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
                default: st_next = SEQ_IDLE;
            endcase
        end
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                st_reg  <= SEQ_IDLE;
                cnt_reg <= 8'h00;
            end else begin
                st_reg  <= st_next;
                cnt_reg <= cnt_next;
            end
        end
        assign active[i] = (st_reg == SEQ_HOLD);
        assign done[i]   = (st_reg == SEQ_HOLD) && (cnt_reg == 8'h00);
        a_hold_length:
        assert property (@(posedge hclk) disable iff (!hresetn)
            $rose(active[i]) |-> active[i] ##9 done[i])
            else $error("reset hold length wrong");
    end
endmodule : scrwc_rst_seq

// file: verilog/scrwc_timer.sv
// Clock divider, general timer and free-running counter
`timescale 1ns/1ps
`include "scrwc_consts.svh"
module scrwc_timer (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Control
    input  wire logic        clr,
    input  wire logic        enable,
    input  wire logic [15:0] reload,
    // Status
    output logic             tick,
    output logic             expire,
    output logic      [15:0] count_reg,
    output logic      [31:0] free_reg
);
    localparam logic [7:0] TICK_LAST = 8'(`SCRWC_TICK_CYC - 1);
    logic [7:0]  div_reg, div_next;
    logic [15:0] count_next;
    logic [31:0] free_next;
    always_comb begin
        div_next   = (div_reg == 8'h00) ? TICK_LAST : div_reg - 8'h01;
        free_next  = free_reg + 32'h0000_0001;
        count_next = count_reg;
        expire     = 1'b0;
        if (clr || !enable) begin
            count_next = reload;
        end else if (tick) begin
            if (count_reg == 16'h0000) begin
                count_next = reload;
                expire     = 1'b1;
            end else begin
                count_next = count_reg - 16'h0001;
            end
        end
    end
    assign tick = (div_reg == 8'h00);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg   <= 8'h00;
            count_reg <= `SCRWC_TMR_RELOAD_RST;
            free_reg  <= 32'h0000_0000;
        end else begin
            div_reg   <= div_next;
            count_reg <= count_next;
            free_reg  <= free_next;
        end
    end
    a_timer_reload:
    assert property (@(posedge hclk) disable iff (!hresetn)
        expire |=> count_reg == $past(reload))
        else $error("timer did not reload");
endmodule : scrwc_timer

// file: verilog/scrwc_ctrl.sv
// Clock, reset and wake controller with AHB-Lite registers
`timescale 1ns/1ps
`include "scrwc_consts.svh"
module scrwc_ctrl
    import scrwc_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Chip reset sources
    input  wire logic        por_n,
    input  wire logic        ext_reset_n_pin,
    // Wake event sources
    input  wire logic        wake_frame_det,
    input  wire logic        energy_det,
    input  wire logic        magic_det,
    // Reset and clock outputs
    output logic             digital_rst,
    output logic             soft_rst,
    output logic             port1_rst,
    output logic             port2_rst,
    output logic             virtual_rst,
    output logic             module_clk_en,
    // Wake and interrupt
    output logic             wake_event_output,
    output logic             irq
);
    logic                  wr_en_reg, wr_en_next;
    logic [7:0]            addr_reg, addr_next;
    logic [31:0]           hrdata_reg, hrdata_next;
    logic [2:0]            reset_control_reg, rst_ctl_next;
    logic                  soft_reset_bit, soft_bit_next;
    logic [3:0]            wake_cfg_reg, wake_cfg_next;
    logic                  vrst_bit_reg, vrst_bit_next;
    logic [2:0]            wake_sts_reg, wake_sts_next;
    logic                  p1_basic_reg, p1_basic_next;
    logic                  p2_basic_reg, p2_basic_next;
    logic                  v_basic_reg, v_basic_next;
    logic [16:0]           tmr_ctl_reg, tmr_ctl_next;
    logic [2:0]            int_sts_reg, int_sts_next;
    logic [2:0]            int_mask_reg, int_mask_next;
    logic [31:0]           scratch_reg, scratch_next;
    logic [4:0]            rst_out_reg, rst_out_next;
    logic                  wake_out_reg, wake_out_next;
    logic [`SCRWC_NCH-1:0] start_vec, seq_active, seq_done;
    logic [2:0]            wake_ev, int_ev;
    logic                  addr_ph, chip_req, soft_clr, rd_sts;
    logic                  tmr_tick, tmr_expire;
    logic [15:0]           tmr_count;
    logic [31:0]           free_count;
    logic                  w_rst, w_pmt, w_wsts, w_p1, w_p2, w_vb;

    assign addr_ph   = hsel && htrans[1] && hready;
    assign chip_req  = !por_n || !ext_reset_n_pin;
    assign soft_clr  = seq_active[`SCRWC_CH_SOFT] || seq_active[`SCRWC_CH_DIG];
    assign rd_sts    = addr_ph && !hwrite && (haddr[7:0] == `SCRWC_OFF_INT_STS);
    assign w_rst     = wr_en_reg && (addr_reg == `SCRWC_OFF_RST_CTL);
    assign w_pmt     = wr_en_reg && (addr_reg == `SCRWC_OFF_PMT);
    assign w_wsts    = wr_en_reg && (addr_reg == `SCRWC_OFF_WAKE_STS);
    assign w_p1      = wr_en_reg && (addr_reg == `SCRWC_OFF_P1_BASIC);
    assign w_p2      = wr_en_reg && (addr_reg == `SCRWC_OFF_P2_BASIC);
    assign w_vb      = wr_en_reg && (addr_reg == `SCRWC_OFF_V_BASIC);
    assign wake_ev   = {magic_det, energy_det, wake_frame_det} & wake_cfg_reg[2:0];

    // Reset starts
    always_comb begin
        start_vec = '0;
        start_vec[`SCRWC_CH_DIG] = w_rst && hwdata[`SCRWC_BIT_DIG_RST]
            && !reset_control_reg[`SCRWC_BIT_DIG_RST];
        start_vec[`SCRWC_CH_SOFT] = wr_en_reg && (addr_reg == `SCRWC_OFF_HARDWARE_CONFIG_REG)
            && hwdata[`SCRWC_BIT_SOFT_RST] && !soft_reset_bit;
        start_vec[`SCRWC_CH_P1] = ((w_rst && hwdata[`SCRWC_BIT_P1_RST])
            || (w_p1 && hwdata[`SCRWC_BIT_BASIC_RST]))
            && !seq_active[`SCRWC_CH_P1];
        start_vec[`SCRWC_CH_P2] = ((w_rst && hwdata[`SCRWC_BIT_P2_RST])
            || (w_p2 && hwdata[`SCRWC_BIT_BASIC_RST]))
            && !seq_active[`SCRWC_CH_P2];
        start_vec[`SCRWC_CH_VIRT] = (start_vec[`SCRWC_CH_DIG]
            || (w_pmt && hwdata[`SCRWC_BIT_PMT_VRST])
            || (w_vb && hwdata[`SCRWC_BIT_BASIC_RST]))
            && !seq_active[`SCRWC_CH_VIRT];
    end

    scrwc_rst_seq u_seq (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (start_vec),
        .active  (seq_active),
        .done    (seq_done)
    );

    scrwc_timer u_timer (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clr       (chip_req || soft_clr),
        .enable    (tmr_ctl_reg[`SCRWC_BIT_TMR_EN]),
        .reload    (tmr_ctl_reg[15:0]),
        .tick      (tmr_tick),
        .expire    (tmr_expire),
        .count_reg (tmr_count),
        .free_reg  (free_count)
    );

    assign int_ev = {|seq_done, |(wake_ev & ~wake_sts_reg), tmr_expire};

    // Read data mux, sampled in the address phase
    always_comb begin
        hrdata_next = 32'h0000_0000;
        case (haddr[7:0])
            `SCRWC_OFF_RST_CTL:  hrdata_next[2:0] = reset_control_reg;
            `SCRWC_OFF_HARDWARE_CONFIG_REG:   hrdata_next[0] = soft_reset_bit;
            `SCRWC_OFF_PMT:      hrdata_next = {21'h0, vrst_bit_reg, 6'h0, wake_cfg_reg};
            `SCRWC_OFF_WAKE_STS: hrdata_next[2:0] = wake_sts_reg;
            `SCRWC_OFF_P1_BASIC: hrdata_next[15] = p1_basic_reg;
            `SCRWC_OFF_P2_BASIC: hrdata_next[15] = p2_basic_reg;
            `SCRWC_OFF_V_BASIC:  hrdata_next[15] = v_basic_reg;
            `SCRWC_OFF_TMR_CTL:  hrdata_next[16:0] = tmr_ctl_reg;
            `SCRWC_OFF_TMR_CNT:  hrdata_next[15:0] = tmr_count;
            `SCRWC_OFF_FREE_CNT: hrdata_next = free_count;
            `SCRWC_OFF_INT_STS:  hrdata_next[2:0] = int_sts_reg;
            `SCRWC_OFF_INT_MASK: hrdata_next[2:0] = int_mask_reg;
            `SCRWC_OFF_SCRATCH:  hrdata_next = scratch_reg;
            default:             hrdata_next = 32'h0000_0000;
        endcase
        if (!addr_ph || hwrite) begin
            hrdata_next = hrdata_reg;
        end
    end

    // Register next values
    always_comb begin
        wr_en_next    = addr_ph && hwrite;
        addr_next     = addr_ph ? haddr[7:0] : addr_reg;
        rst_ctl_next  = reset_control_reg & ~{seq_done[`SCRWC_CH_P2],
            seq_done[`SCRWC_CH_P1], seq_done[`SCRWC_CH_DIG]};
        soft_bit_next = soft_reset_bit && !seq_done[`SCRWC_CH_SOFT];
        vrst_bit_next = vrst_bit_reg && !seq_done[`SCRWC_CH_VIRT];
        p1_basic_next = p1_basic_reg && !seq_done[`SCRWC_CH_P1];
        p2_basic_next = p2_basic_reg && !seq_done[`SCRWC_CH_P2];
        v_basic_next  = v_basic_reg && !seq_done[`SCRWC_CH_VIRT];
        wake_cfg_next = wake_cfg_reg;
        wake_sts_next = wake_sts_reg;
        tmr_ctl_next  = tmr_ctl_reg;
        int_mask_next = int_mask_reg;
        scratch_next  = scratch_reg;
        int_sts_next  = int_sts_reg;
        if (w_rst) begin
            rst_ctl_next = rst_ctl_next | (hwdata[2:0] & {start_vec[`SCRWC_CH_P2],
                start_vec[`SCRWC_CH_P1], start_vec[`SCRWC_CH_DIG]});
        end
        if (start_vec[`SCRWC_CH_SOFT]) begin
            soft_bit_next = 1'b1;
        end
        if (w_pmt) begin
            wake_cfg_next = hwdata[3:0];
            vrst_bit_next = vrst_bit_next || (hwdata[`SCRWC_BIT_PMT_VRST]
                && start_vec[`SCRWC_CH_VIRT]);
        end
        if (w_p1 && start_vec[`SCRWC_CH_P1]) begin
            p1_basic_next = hwdata[`SCRWC_BIT_BASIC_RST];
        end
        if (w_p2 && start_vec[`SCRWC_CH_P2]) begin
            p2_basic_next = hwdata[`SCRWC_BIT_BASIC_RST];
        end
        if (w_vb && start_vec[`SCRWC_CH_VIRT]) begin
            v_basic_next = hwdata[`SCRWC_BIT_BASIC_RST];
        end
        if (w_wsts) begin
            wake_sts_next = 3'h0;
        end
        wake_sts_next = wake_sts_next | wake_ev;
        if (wr_en_reg && (addr_reg == `SCRWC_OFF_TMR_CTL)) begin
            tmr_ctl_next = hwdata[16:0];
        end
        if (wr_en_reg && (addr_reg == `SCRWC_OFF_INT_MASK)) begin
            int_mask_next = hwdata[2:0];
        end
        if (wr_en_reg && (addr_reg == `SCRWC_OFF_SCRATCH)) begin
            scratch_next = hwdata;
        end
        if (rd_sts) begin
            int_sts_next = 3'h0;
        end
        int_sts_next = int_sts_next | int_ev;
        if (soft_clr) begin
            tmr_ctl_next  = {1'b0, `SCRWC_TMR_RELOAD_RST};
            int_mask_next = 3'h0;
            int_sts_next  = int_ev;
            wake_sts_next = wake_ev; // Scratch and wake config kept
        end
        rst_out_next = {5{chip_req}} | seq_active;
        rst_out_next[`SCRWC_CH_SOFT] = rst_out_next[`SCRWC_CH_SOFT]
            || seq_active[`SCRWC_CH_DIG];
        wake_out_next = wake_cfg_reg[`SCRWC_BIT_PMT_WOUT] && (|wake_sts_reg);
        if (chip_req) begin
            rst_ctl_next  = 3'h0;
            soft_bit_next = 1'b0;
            vrst_bit_next = 1'b0;
            p1_basic_next = 1'b0;
            p2_basic_next = 1'b0;
            v_basic_next  = 1'b0;
            wake_cfg_next = 4'h0;
            wake_sts_next = 3'h0;
            tmr_ctl_next  = {1'b0, `SCRWC_TMR_RELOAD_RST};
            int_mask_next = 3'h0;
            int_sts_next  = 3'h0;
            scratch_next  = 32'h0000_0000;
            wake_out_next = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_en_reg         <= 1'b0;
            addr_reg          <= 8'h00;
            hrdata_reg        <= 32'h0000_0000;
            reset_control_reg <= 3'h0;
            soft_reset_bit    <= 1'b0;
            wake_cfg_reg      <= 4'h0;
            vrst_bit_reg      <= 1'b0;
            wake_sts_reg      <= 3'h0;
            p1_basic_reg      <= 1'b0;
            p2_basic_reg      <= 1'b0;
            v_basic_reg       <= 1'b0;
            tmr_ctl_reg       <= {1'b0, `SCRWC_TMR_RELOAD_RST};
            int_sts_reg       <= 3'h0;
            int_mask_reg      <= 3'h0;
            scratch_reg       <= 32'h0000_0000;
            rst_out_reg       <= 5'h1F;
            wake_out_reg      <= 1'b0;
        end else begin
            wr_en_reg         <= wr_en_next;
            addr_reg          <= addr_next;
            hrdata_reg        <= hrdata_next;
            reset_control_reg <= rst_ctl_next;
            soft_reset_bit    <= soft_bit_next;
            wake_cfg_reg      <= wake_cfg_next;
            vrst_bit_reg      <= vrst_bit_next;
            wake_sts_reg      <= wake_sts_next;
            p1_basic_reg      <= p1_basic_next;
            p2_basic_reg      <= p2_basic_next;
            v_basic_reg       <= v_basic_next;
            tmr_ctl_reg       <= tmr_ctl_next;
            int_sts_reg       <= int_sts_next;
            int_mask_reg      <= int_mask_next;
            scratch_reg       <= scratch_next;
            rst_out_reg       <= rst_out_next;
            wake_out_reg      <= wake_out_next;
        end
    end

    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = hrdata_reg;
    assign digital_rst       = rst_out_reg[`SCRWC_CH_DIG];
    assign soft_rst          = rst_out_reg[`SCRWC_CH_SOFT];
    assign port1_rst         = rst_out_reg[`SCRWC_CH_P1];
    assign port2_rst         = rst_out_reg[`SCRWC_CH_P2];
    assign virtual_rst       = rst_out_reg[`SCRWC_CH_VIRT];
    assign module_clk_en     = tmr_tick;
    assign wake_event_output = wake_out_reg;
    assign irq               = |(int_sts_reg & int_mask_reg);

    a_chip_reset_all:
    assert property (@(posedge hclk) disable iff (!hresetn)
        chip_req |=> digital_rst && soft_rst && port1_rst && port2_rst && virtual_rst)
        else $error("chip reset did not assert all resets");
    a_digital_spares_port:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (seq_active[`SCRWC_CH_DIG] && !seq_active[`SCRWC_CH_P1] && !chip_req)
        |=> digital_rst && soft_rst && !port1_rst)
        else $error("digital reset scope wrong");
    a_soft_scope_only:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (seq_active[`SCRWC_CH_SOFT] && !seq_active[`SCRWC_CH_DIG] && !chip_req)
        |=> soft_rst && !digital_rst)
        else $error("soft reset scope wrong");
    a_port2_start:
    assert property (@(posedge hclk) disable iff (!hresetn)
        start_vec[`SCRWC_CH_P2] |=> ##1 port2_rst)
        else $error("port 2 reset not issued");
    a_port1_start:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (w_p1 && hwdata[`SCRWC_BIT_BASIC_RST] && !seq_active[`SCRWC_CH_P1])
        |-> ##2 port1_rst)
        else $error("port 1 reset not issued");
    a_virt_from_pmt:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (w_pmt && hwdata[`SCRWC_BIT_PMT_VRST] && !seq_active[`SCRWC_CH_VIRT])
        |-> ##2 virtual_rst)
        else $error("virtual reset not issued");
    a_wake_drives_out:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (wake_cfg_reg[`SCRWC_BIT_PMT_WOUT] && (|wake_sts_reg) && !chip_req)
        |=> wake_event_output)
        else $error("wake output missing");
    a_wac_clears:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (w_wsts && !magic_det && !energy_det && !wake_frame_det)
        |=> wake_sts_reg == 3'h0)
        else $error("wake status not cleared");
    a_scratch_kept:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (soft_clr && !chip_req && !(wr_en_reg && addr_reg == `SCRWC_OFF_SCRATCH))
        |=> $stable(scratch_reg))
        else $error("immune register changed");
    a_dig_self_clear:
    assert property (@(posedge hclk) disable iff (!hresetn)
        seq_done[`SCRWC_CH_DIG] |=> !reset_control_reg[`SCRWC_BIT_DIG_RST])
        else $error("request bit not cleared");
endmodule : scrwc_ctrl

// file: verification/scrwc_submod_model.sv
// Model of the sub-modules that take resets and raise wake events
`timescale 1ns/1ps
module scrwc_submod_model (
    // Clock and control
    input  wire logic       hclk,
    input  wire logic       clr,
    // Resets from the controller
    input  wire logic [4:0] rst_vec,
    // Wake event sources
    output logic      [2:0] wake_src
);
    logic [4:0] seen;
    int         width;
    initial begin
        wake_src = 3'h0;
    end
    // Record which resets fired and for how many cycles
    always @(posedge hclk) begin
        seen  <= clr ? 5'h00 : (seen | rst_vec);
        width <= clr ? 0 : (width + int'(rst_vec != 5'h00));
    end
    task automatic pulse(input int i);
        wake_src[i] <= 1'b1;
        @(posedge hclk);
        wake_src[i] <= 1'b0;
    endtask : pulse
endmodule : scrwc_submod_model

// file: verification/tb_scrwc_ctrl.sv
// Testbench of the clock, reset and wake controller
`timescale 1ns/1ps
module tb_scrwc_ctrl;
    logic        hclk, hresetn, hsel, hwrite, por_n, ext_reset_n_pin, clr, hready;
    logic        module_clk_en, wake_event_output, irq, hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, r2;
    wire  [4:0]  rst_vec;
    logic [2:0]  wake_src;
    int          n_mismatch, check_count, cyc, k;
    logic [31:0] ra [8] = '{32'h00, 32'h04, 32'h00, 32'h00, 32'h10, 32'h14, 32'h18, 32'h08};
    logic [31:0] rv [8] = '{32'h1, 32'h1, 32'h2, 32'h4, 32'h8000, 32'h8000, 32'h8000, 32'h400};
    logic [4:0]  re [8] = '{5'h13, 5'h02, 5'h04, 5'h08, 5'h04, 5'h08, 5'h10, 5'h10};
    scrwc_ctrl scrwc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .por_n(por_n),
        .ext_reset_n_pin(ext_reset_n_pin), .wake_frame_det(wake_src[0]),
        .energy_det(wake_src[1]), .magic_det(wake_src[2]), .digital_rst(rst_vec[0]),
        .soft_rst(rst_vec[1]), .port1_rst(rst_vec[2]), .port2_rst(rst_vec[3]),
        .virtual_rst(rst_vec[4]), .module_clk_en(module_clk_en),
        .wake_event_output(wake_event_output), .irq(irq));
    scrwc_submod_model model (.hclk(hclk), .clr(clr), .rst_vec(rst_vec), .wake_src(wake_src));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic final_report();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic rd_chk(input string n, input logic [31:0] a, e);
        xfer(1'b0, a, 32'h0, rd);
        check(n, e, rd);
    endtask : rd_chk
    initial begin
        {hresetn, hsel, hwrite, clr, htrans, haddr, hwdata} = '0;
        {por_n, ext_reset_n_pin} = 2'h3;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        check("rst_idle", 32'h0, {27'h0, rst_vec});
        rd_chk("tmr_ctl", 32'h1C, 32'h0000FFFF);
        xfer(1'b1, 32'h40, 32'hFFFFFFFF, rd);
        rd_chk("unmapped", 32'h40, 32'h0);
        check("hresp", 32'h0, {31'h0, hresp});
        for (k = 0; k < 8; k++) begin
            clr <= 1'b1;
            @(posedge hclk);
            clr <= 1'b0;
            xfer(1'b1, ra[k], rv[k], rd);
            rd_chk("req_bit", ra[k], rv[k]);
            repeat (14) @(posedge hclk);
            rd_chk("self_clr", ra[k], 32'h0);
            check("rst_set", {27'h0, re[k]}, {27'h0, model.seen});
            check("rst_len", 32'hA, model.width);
        end
        xfer(1'b0, 32'h24, 32'h0, rd);
        xfer(1'b0, 32'h24, 32'h0, r2);
        check("free_cnt", 32'h2, r2 - rd);
        k = 0;
        repeat (100) begin
            @(posedge hclk);
            k += int'(module_clk_en === 1'b1);
        end
        check("clk_en", 32'hA, k);
        xfer(1'b1, 32'h30, 32'hA5A55A5A, rd);
        xfer(1'b1, 32'h08, 32'h9, rd);
        xfer(1'b1, 32'h04, 32'h1, rd);
        repeat (15) @(posedge hclk);
        rd_chk("scratch", 32'h30, 32'hA5A55A5A);
        rd_chk("pmt_keep", 32'h08, 32'h9);
        for (k = 0; k < 3; k++) begin
            xfer(1'b1, 32'h08, 32'h8 | (32'h1 << k), rd);
            model.pulse(k);
            repeat (3) @(posedge hclk);
            check("wake_out", 32'h1, {31'h0, wake_event_output});
            rd_chk("wake_sts", 32'h0C, 32'h1 << k);
            xfer(1'b1, 32'h0C, 32'h0, rd);
            rd_chk("wake_clr", 32'h0C, 32'h0);
        end
        xfer(1'b1, 32'h2C, 32'h0, rd);
        // Load the reload value while disabled, then enable
        xfer(1'b1, 32'h1C, 32'h00000003, rd);
        xfer(1'b1, 32'h1C, 32'h00010003, rd);
        repeat (60) @(posedge hclk);
        check("irq_mask", 32'h0, {31'h0, irq});
        xfer(1'b1, 32'h2C, 32'h1, rd);
        @(posedge hclk);
        check("irq_on", 32'h1, {31'h0, irq});
        // Stop the timer first so no new expiry races the clear
        xfer(1'b1, 32'h1C, 32'h0, rd);
        xfer(1'b0, 32'h28, 32'h0, rd);
        check("tmr_exp", 32'h1, rd & 32'h1);
        check("irq_off", 32'h0, {31'h0, irq});
        for (k = 0; k < 2; k++) begin
            xfer(1'b1, 32'h30, 32'h1234, rd);
            {por_n, ext_reset_n_pin} <= k[0] ? 2'h1 : 2'h2;
            repeat (3) @(posedge hclk);
            check("chip_rst", 32'h1F, {27'h0, rst_vec});
            {por_n, ext_reset_n_pin} <= 2'h3;
            repeat (2) @(posedge hclk);
            rd_chk("chip_clr", 32'h30, 32'h0);
        end
        final_report();
    end
endmodule : tb_scrwc_ctrl
